// File: common/mcdac_regs.vh
/*
 * Register map, field positions, reset values and timing counts for the
 * common drop/add control block of the four-port E1 mapper.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MCDAC_REGS_VH
`define MCDAC_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets (printed offsets are indices; byte address is four times)
// ----------------------------------------------------------------------------
`define MCDAC_IDX_COMMON_CTRL 10'h013
`define MCDAC_IDX_MASTER_RESET 10'h015
`define MCDAC_IDX_STATUS 10'h100
`define MCDAC_ADDR_COMMON_CTRL 12'h04c
`define MCDAC_ADDR_MASTER_RESET 12'h054
`define MCDAC_ADDR_STATUS 12'h400

// ----------------------------------------------------------------------------
// Common control field positions
// ----------------------------------------------------------------------------
`define MCDAC_BIT_AIS_EN 7
`define MCDAC_BIT_DROP_V1_SEL 6
`define MCDAC_BIT_ADD_V1_REF 5
`define MCDAC_BIT_RDI_EN 4
`define MCDAC_BIT_NULL_ZERO 3
`define MCDAC_BIT_DIND_DELAY 2
`define MCDAC_BIT_UNEQ_EN 1
`define MCDAC_BIT_OBIT_ZERO 0
`define MCDAC_BIT_MASTER_RESET 7

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define MCDAC_CTRL_RESET 8'h00
`define MCDAC_NULL_FILL_BYTE 8'h00
`define MCDAC_RESET_CYCLES 4'h4

`endif

// File: src/mcdac_ind_delay.v
/*
 * Drop slot indicator delay stage: one or two flops per bus.
 * Assumes indicator inputs are synchronous to clk.
 */
module mcdac_ind_delay #(
    parameter WIDTH = 2
) (
    input wire clk,
    input wire sys_rst,
    input wire extra_delay,
    input wire [WIDTH-1:0] ind_in,
    output reg [WIDTH-1:0] ind_out_ff
);

    reg [WIDTH-1:0] stage_ff;
    reg [WIDTH-1:0] nxt_ind_out;

    // Base stage plus optional extra stage
    always @(posedge clk) begin
        if (sys_rst) begin
            stage_ff <= {WIDTH{1'b0}};
            ind_out_ff <= {WIDTH{1'b0}};
        end else begin
            stage_ff <= ind_in;
            ind_out_ff <= nxt_ind_out;
        end
    end

    // Pick direct or once-more delayed indicator
    always @* begin
        nxt_ind_out = extra_delay ? stage_ff : ind_in;
    end

endmodule // mcdac_ind_delay

// File: src/mcdac_common_ctrl.v
/*
 * Common drop/add control register with APB slave and the steering logic
 * it drives: AIS/RDI responses, V1 pulse sources, null-column fill,
 * drop indicator delay and O-bit zero fill for four ports.
 * Assumes all inputs are synchronous to clk (the bus byte clock) and that
 * detector levels and frame pulses come from the surrounding mapper logic.
 * Assumes software never sets the drop V1 source bit in drop bus timing
 * mode; nothing here guards against it.
 * Assumes the three-state pad for the fill byte sits outside this block
 * and takes the active-low enable as its driver control.
 * Assumes a master reset lasts a few cycles; control writes landing in
 * that time are dropped.
 */
// Chosen here: the APB interface to the registers.
`include "mcdac_regs.vh"

module mcdac_common_ctrl #(
    parameter PORTS = 4,
    parameter OBITS = 4
) (
    input wire clk,
    input wire sys_rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_ff,
    output reg pready_ff,
    output reg pslverr_ff,
    // Timing mode and V1 sources
    input wire add_bus_timing,
    input wire h4_v1_pulse,
    input wire drop_frame_marker_signal,
    input wire add_frame_marker_signal,
    output reg drop_v1_pulse_ff,
    output reg add_v1_pulse_ff,
    // Drop alarms
    input wire drop_ais_detected,
    input wire drop_unequipped_detected,
    input wire [PORTS-1:0] rx_alarm,
    input wire [PORTS-1:0] per_port_rdi_control,
    output reg [PORTS-1:0] line_ais_ff,
    output reg [PORTS-1:0] tx_rdi_ff,
    output reg [PORTS-1:0] tandem_outgoing_defect_alarm_ff,
    output reg [PORTS-1:0] tandem_remote_defect_alarm_ff,
    // Null column fill
    input wire null_pointer_group_a_enable,
    input wire null_pointer_group_b_enable,
    input wire null_pointer_group_c_enable,
    input wire [1:0] null_column_group,
    input wire null_column_slot,
    output reg [7:0] bus_data_ff,
    output reg bus_data_oe_n_ff,
    // Drop slot indicators
    input wire a_drop_slot_indicator,
    input wire b_drop_slot_indicator,
    output wire a_drop_slot_indicator_out,
    output wire b_drop_slot_indicator_out,
    // O-bit channel
    input wire [PORTS*OBITS-1:0] obit_sw_values,
    output reg [PORTS*OBITS-1:0] obit_tx_ff
);

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    // Control byte, master reset counter and registered bus answer
    reg [7:0] ctrl_ff;
    reg [7:0] nxt_ctrl;
    reg [3:0] mreset_cnt_ff;
    reg [3:0] nxt_mreset_cnt;
    reg [31:0] nxt_prdata;
    reg nxt_pready;
    reg nxt_pslverr;

    // ------------------------------------------------------------------------
    // Control field taps
    // ------------------------------------------------------------------------
    // Alarm response and V1 steering bits
    wire ais_en = ctrl_ff[`MCDAC_BIT_AIS_EN];
    wire drop_v1_sel = ctrl_ff[`MCDAC_BIT_DROP_V1_SEL];
    wire add_v1_ref = ctrl_ff[`MCDAC_BIT_ADD_V1_REF];
    wire rdi_en = ctrl_ff[`MCDAC_BIT_RDI_EN];

    // Bus fill, indicator delay, unequipped and O-bit bits
    wire null_zero = ctrl_ff[`MCDAC_BIT_NULL_ZERO];
    wire dind_delay = ctrl_ff[`MCDAC_BIT_DIND_DELAY];
    wire uneq_en = ctrl_ff[`MCDAC_BIT_UNEQ_EN];
    wire obit_zero = ctrl_ff[`MCDAC_BIT_OBIT_ZERO];

    // Master reset is in progress while the counter is non-zero
    wire mreset_busy = (mreset_cnt_ff != 4'h0);

    // Address decode shared by read and write paths
    function [1:0] reg_sel;
        input [11:0] addr;
        begin
            case (addr)
                `MCDAC_ADDR_COMMON_CTRL: reg_sel = 2'h1;
                `MCDAC_ADDR_MASTER_RESET: reg_sel = 2'h2;
                `MCDAC_ADDR_STATUS: reg_sel = 2'h3;
                default: reg_sel = 2'h0;
            endcase
        end
    endfunction

    // Access phase not yet answered; the raised pready_ff blocks a second take
    wire apb_access = psel && penable && !pready_ff;
    // Which register the current address hits
    wire [1:0] sel = reg_sel(paddr);

    // ------------------------------------------------------------------------
    // APB slave: one wait state, answer registered
    // ------------------------------------------------------------------------
    always @* begin
        nxt_ctrl = ctrl_ff;
        // Reset counter runs down by itself
        nxt_mreset_cnt = mreset_busy ? mreset_cnt_ff - 4'h1 : 4'h0;
        // Idle bus answer unless an access is taken
        nxt_prdata = 32'h0000_0000;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        if (apb_access) begin
            nxt_pready = 1'b1;
            // Unmapped addresses are refused with an error and no effect
            nxt_pslverr = (sel == 2'h0);
            if (pwrite) begin
                // Control byte write; upper write bytes are ignored
                if (sel == 2'h1) begin
                    nxt_ctrl = pwdata[7:0];
                end
                // Master reset strobe restarts the reset count
                if (sel == 2'h2 && pwdata[`MCDAC_BIT_MASTER_RESET]) begin
                    nxt_mreset_cnt = `MCDAC_RESET_CYCLES;
                end
            end else begin
                // Read path; upper bytes read as zero
                case (sel)
                    2'h1: nxt_prdata = {24'h00_0000, ctrl_ff};
                    2'h2: nxt_prdata = {24'h00_0000, mreset_busy, 7'h00};
                    2'h3: nxt_prdata = {24'h00_0000, 4'h0, tx_rdi_ff[0], line_ais_ff[0],
                                        drop_v1_pulse_ff, add_v1_pulse_ff};
                    default: nxt_prdata = 32'h0000_0000;
                endcase
            end
        end
        // Master reset beats a same-cycle write, so the control byte stays
        // zero for the whole reset; software must rewrite it afterwards
        if (mreset_busy) begin
            nxt_ctrl = `MCDAC_CTRL_RESET;
        end
    end

    // Bus and control flops
    always @(posedge clk) begin
        if (sys_rst) begin
            ctrl_ff <= `MCDAC_CTRL_RESET;
            mreset_cnt_ff <= 4'h0;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            mreset_cnt_ff <= nxt_mreset_cnt;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // ------------------------------------------------------------------------
    // V1 multiframe pulse sources
    // ------------------------------------------------------------------------
    // Drop V1 pulse: H4 detector or drop frame marker
    wire drop_v1_src = drop_v1_sel ? drop_frame_marker_signal : h4_v1_pulse;

    // Add V1 pulse follows the drop side only in add timing mode with the reference bit
    wire add_v1_src = (add_bus_timing && add_v1_ref) ? drop_v1_src : add_frame_marker_signal;

    // Both pulses leave on flops, one cycle after their source
    always @(posedge clk) begin
        if (sys_rst) begin
            drop_v1_pulse_ff <= 1'b0;
            add_v1_pulse_ff <= 1'b0;
        end else begin
            drop_v1_pulse_ff <= drop_v1_src;
            add_v1_pulse_ff <= add_v1_src;
        end
    end

    // ------------------------------------------------------------------------
    // Alarm responses per port
    // ------------------------------------------------------------------------
    // Drop bus AIS counts only while the common enable is set
    wire ais_hit = ais_en && drop_ais_detected;
    // Unequipped response, common to both drop buses
    wire uneq_hit = uneq_en && drop_unequipped_detected;
    wire [PORTS-1:0] nxt_line_ais;
    wire [PORTS-1:0] nxt_tx_rdi;
    wire [PORTS-1:0] nxt_tandem_alarm;
    wire [PORTS*OBITS-1:0] nxt_obit_tx;

    // Per-port next values, one slice per port
    genvar p;
    generate
        for (p = 0; p < PORTS; p = p + 1) begin : g_port
            // Line AIS on either enabled alarm source
            assign nxt_line_ais[p] = ais_hit || uneq_hit;

            // Alarm RDI needs both enables; unequipped forces it regardless
            assign nxt_tx_rdi[p] = uneq_hit || (rdi_en && per_port_rdi_control[p]
                                   && (rx_alarm[p] || ais_hit));

            // Both tandem alarms follow the unequipped response
            assign nxt_tandem_alarm[p] = uneq_hit;

            // O-bits and spare bits zeroed or passed from software
            assign nxt_obit_tx[p*OBITS +: OBITS] = obit_zero ? {OBITS{1'b0}}
                                                   : obit_sw_values[p*OBITS +: OBITS];
        end
    endgenerate

    // Alarm output flops; one driver per vector keeps the ports single-sourced
    always @(posedge clk) begin
        if (sys_rst) begin
            line_ais_ff <= {PORTS{1'b0}};
            tx_rdi_ff <= {PORTS{1'b0}};
            tandem_outgoing_defect_alarm_ff <= {PORTS{1'b0}};
            tandem_remote_defect_alarm_ff <= {PORTS{1'b0}};
        end else begin
            line_ais_ff <= nxt_line_ais;
            tx_rdi_ff <= nxt_tx_rdi;
            tandem_outgoing_defect_alarm_ff <= nxt_tandem_alarm;
            tandem_remote_defect_alarm_ff <= nxt_tandem_alarm;
        end
    end

    // O-bit output flops
    always @(posedge clk) begin
        if (sys_rst) begin
            obit_tx_ff <= {(PORTS*OBITS){1'b0}};
        end else begin
            obit_tx_ff <= nxt_obit_tx;
        end
    end

    // ------------------------------------------------------------------------
    // Null pointer column fill
    // ------------------------------------------------------------------------
    // NPI enable of the group that owns the current column
    reg npi_group_on;
    always @* begin
        case (null_column_group)
            2'h0: npi_group_on = null_pointer_group_a_enable;
            2'h1: npi_group_on = null_pointer_group_b_enable;
            2'h2: npi_group_on = null_pointer_group_c_enable;
            default: npi_group_on = 1'b0;
        endcase
    end

    // Drive only a null-column byte of an NPI group with zero fill selected
    wire nxt_bus_data_oe_n = !(null_column_slot && npi_group_on && null_zero);

    // Fill byte and its active-low enable leave on flops
    always @(posedge clk) begin
        if (sys_rst) begin
            bus_data_ff <= 8'h00;
            bus_data_oe_n_ff <= 1'b1;
        end else begin
            bus_data_ff <= `MCDAC_NULL_FILL_BYTE;
            bus_data_oe_n_ff <= nxt_bus_data_oe_n;
        end
    end

    // ------------------------------------------------------------------------
    // Drop slot indicator delay
    // ------------------------------------------------------------------------
    // One delay instance serves both buses, so they never drift apart
    // The extra stage is switched in only while the delay bit is set
    wire [1:0] ind_q;
    mcdac_ind_delay #(
        .WIDTH(2)
    ) u_ind_delay (
        .clk(clk),
        .sys_rst(sys_rst),
        .extra_delay(dind_delay),
        .ind_in({b_drop_slot_indicator, a_drop_slot_indicator}),
        .ind_out_ff(ind_q)
    );
    // Split the delayed pair back onto the two bus outputs
    assign a_drop_slot_indicator_out = ind_q[0];
    assign b_drop_slot_indicator_out = ind_q[1];

endmodule // mcdac_common_ctrl

// File: tb/mcdac_props.sv
/*
 * Checker for the common drop/add control block, bound to its top module.
 * Assumes a single clock domain with synchronous active-high reset.
 */
`include "mcdac_regs.vh"
module mcdac_props #(
    parameter PORTS = 4,
    parameter OBITS = 4
) (
    input logic clk,
    input logic sys_rst,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic pready_ff,
    input logic add_bus_timing,
    input logic h4_v1_pulse,
    input logic drop_frame_marker_signal,
    input logic add_frame_marker_signal,
    input logic drop_v1_pulse_ff,
    input logic add_v1_pulse_ff,
    input logic drop_ais_detected,
    input logic drop_unequipped_detected,
    input logic [PORTS-1:0] line_ais_ff,
    input logic [PORTS-1:0] tx_rdi_ff,
    input logic a_drop_slot_indicator,
    input logic a_drop_slot_indicator_out,
    input logic [PORTS*OBITS-1:0] obit_sw_values,
    input logic [PORTS*OBITS-1:0] obit_tx_ff
);
    logic [7:0] c_ff;
    logic [3:0] rc_ff;
    wire wr = psel && penable && pwrite && !pready_ff;
    // Shadow of the control register; a master reset holds it at zero for its length
    always @(posedge clk) begin
        if (sys_rst) begin
            c_ff <= 8'h00;
            rc_ff <= 4'h0;
        end else begin
            rc_ff <= (rc_ff != 4'h0) ? rc_ff - 4'h1 : 4'h0;
            if (rc_ff != 4'h0)
                c_ff <= 8'h00;
            else if (wr && paddr == `MCDAC_ADDR_COMMON_CTRL)
                c_ff <= pwdata[7:0];
            if (wr && paddr == `MCDAC_ADDR_MASTER_RESET && pwdata[7])
                rc_ff <= `MCDAC_RESET_CYCLES;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_drop_v1_src: assert property (!$past(sys_rst) |->
        drop_v1_pulse_ff == ($past(c_ff[6]) ? $past(drop_frame_marker_signal) : $past(h4_v1_pulse)))
        else $error("drop v1 source wrong");
    a_add_v1_src: assert property (!$past(sys_rst) |->
        add_v1_pulse_ff == ($past(add_bus_timing && c_ff[5]) ? drop_v1_pulse_ff : $past(add_frame_marker_signal)))
        else $error("add v1 source wrong");
    a_ind_delay: assert property (!$past(sys_rst) && !$past(sys_rst, 2) && $past(c_ff[2]) == $past(c_ff[2], 2) |->
        a_drop_slot_indicator_out == ($past(c_ff[2]) ? $past(a_drop_slot_indicator, 2) : $past(a_drop_slot_indicator)))
        else $error("indicator delay wrong");
    a_obit_fill: assert property (!$past(sys_rst) |->
        obit_tx_ff == ($past(c_ff[0]) ? '0 : $past(obit_sw_values))) else $error("obit fill wrong");
    a_line_ais: assert property (!$past(sys_rst) |-> line_ais_ff == {PORTS{$past(
        c_ff[7] && drop_ais_detected || c_ff[1] && drop_unequipped_detected)}}) else $error("line ais wrong");
    a_rdi_off: assert property (!$past(sys_rst) && $past(!c_ff[4] && !(c_ff[1] && drop_unequipped_detected)) |->
        tx_rdi_ff == '0) else $error("rdi without enable");
    a_ready_wait: assert property (psel && penable && !pready_ff |=> pready_ff) else $error("no ready");
    a_ready_pulse: assert property (pready_ff |=> !pready_ff) else $error("ready too long");
endmodule // mcdac_props

bind mcdac_common_ctrl mcdac_props #(
    .PORTS(PORTS),
    .OBITS(OBITS)
) u_mcdac_props (
    .clk(clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready_ff(pready_ff),
    .add_bus_timing(add_bus_timing),
    .h4_v1_pulse(h4_v1_pulse),
    .drop_frame_marker_signal(drop_frame_marker_signal),
    .add_frame_marker_signal(add_frame_marker_signal),
    .drop_v1_pulse_ff(drop_v1_pulse_ff),
    .add_v1_pulse_ff(add_v1_pulse_ff),
    .drop_ais_detected(drop_ais_detected),
    .drop_unequipped_detected(drop_unequipped_detected),
    .line_ais_ff(line_ais_ff),
    .tx_rdi_ff(tx_rdi_ff),
    .a_drop_slot_indicator(a_drop_slot_indicator),
    .a_drop_slot_indicator_out(a_drop_slot_indicator_out),
    .obit_sw_values(obit_sw_values),
    .obit_tx_ff(obit_tx_ff)
);

// File: tb/mcdac_bus_model.sv
/*
 * Far-side bus timing model: periodic H4 and frame marker pulses.
 * Assumes clk is the bus byte clock; periods 5, 7 and 3 keep sources apart.
 */
module mcdac_bus_model (
    input logic clk,
    input logic sys_rst,
    output logic h4_v1_pulse,
    output logic drop_frame_marker_signal,
    output logic add_frame_marker_signal
);
    timeunit 1ns;
    timeprecision 1ns;
    int n_ff;
    // Free running position counter
    always @(posedge clk) begin
        n_ff <= sys_rst ? 0 : n_ff + 1;
    end
    assign h4_v1_pulse = (n_ff % 5 == 4);
    assign drop_frame_marker_signal = (n_ff % 7 == 3);
    assign add_frame_marker_signal = (n_ff % 3 == 1);
endmodule // mcdac_bus_model

// File: tb/mcdac_common_ctrl_tb.sv
/*
 * Self-checking bench for the common drop/add control block.
 * Assumes APB slave answering after one wait state and the bus timing model.
 */
module mcdac_common_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, add_bus_timing = 0, er;
    logic drop_ais_detected = 0, drop_unequipped_detected = 0, null_column_slot = 0;
    logic null_pointer_group_a_enable = 0, null_pointer_group_b_enable = 0, null_pointer_group_c_enable = 0;
    logic a_drop_slot_indicator = 0, b_drop_slot_indicator = 0, pready_ff, pslverr_ff, bus_data_oe_n_ff;
    logic h4_v1_pulse, drop_frame_marker_signal, add_frame_marker_signal, drop_v1_pulse_ff, add_v1_pulse_ff;
    logic a_drop_slot_indicator_out, b_drop_slot_indicator_out;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, prdata_ff;
    logic [3:0] rx_alarm = 0, per_port_rdi_control = 4'h3, line_ais_ff, tx_rdi_ff;
    logic [3:0] tandem_outgoing_defect_alarm_ff, tandem_remote_defect_alarm_ff;
    logic [1:0] null_column_group = 0;
    logic [7:0] bus_data_ff;
    logic [15:0] obit_sw_values = 0, obit_tx_ff;
    int n_fail = 0, n_tests = 0, cyc = 0;
    mcdac_common_ctrl u_mcdac_common_ctrl (.*);
    mcdac_bus_model u_mcdac_bus_model (.*);
    always #5 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'h0;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready_ff !== 1'h1);
        rd = prdata_ff;
        er = pslverr_ff;
        psel <= 1'h0; penable <= 1'h0;
    endtask
    task automatic v1(input logic [7:0] c, input logic t, input int ed, ea);
        int nd, na;
        nd = 0;
        na = 0;
        add_bus_timing <= t;
        apb(1'h1, 12'h04c, {24'h0, c});
        apb(1'h0, 12'h04c, 32'h0);
        chk("v1_ctrl", rd, {24'h0, c});
        repeat (3) @(posedge clk);
        repeat (105) begin
            @(posedge clk);
            nd += (drop_v1_pulse_ff === 1'h1);
            na += (add_v1_pulse_ff === 1'h1);
        end
        chk("drop_v1", nd, ed);
        chk("add_v1", na, ea);
    endtask
    task automatic al(input logic [7:0] c, input logic a, u, input logic [3:0] rx, el, r, tn);
        apb(1'h1, 12'h04c, {24'h0, c});
        drop_ais_detected <= a; drop_unequipped_detected <= u; rx_alarm <= rx;
        repeat (3) @(posedge clk);
        chk("line_ais", line_ais_ff, el);
        chk("tx_rdi", tx_rdi_ff, r);
        chk("tandem", {tandem_outgoing_defect_alarm_ff, tandem_remote_defect_alarm_ff}, {tn, tn});
    endtask
    task automatic ind(input logic d);
        int n;
        apb(1'h1, 12'h04c, {29'h0, d, 2'h0});
        a_drop_slot_indicator <= 1'h1; b_drop_slot_indicator <= 1'h1;
        @(posedge clk);
        a_drop_slot_indicator <= 1'h0; b_drop_slot_indicator <= 1'h0;
        n = 0;
        while (a_drop_slot_indicator_out !== 1'h1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        chk("a_ind_lat", n, 1 + d);
        chk("b_ind", b_drop_slot_indicator_out, 1'h1);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'h0;
        apb(1'h0, 12'h04c, 32'h0);
        chk("ctrl_reset", rd, 32'h0);
        apb(1'h1, 12'h04c, 32'ha5);
        apb(1'h0, 12'h04c, 32'h0);
        chk("readback", rd, 32'ha5);
        apb(1'h1, 12'h04c, 32'h1a);
        apb(1'h0, 12'h04c, 32'h0);
        chk("readback2", rd, 32'h1a);
        apb(1'h0, 12'h008, 32'h0);
        chk("unmapped", er, 1'h1);
        v1(8'h00, 1'h0, 21, 35);
        v1(8'h40, 1'h1, 15, 35);
        v1(8'h20, 1'h1, 21, 21);
        v1(8'h60, 1'h1, 15, 15);
        al(8'h80, 1'h1, 1'h0, 4'h0, 4'hf, 4'h0, 4'h0);
        add_bus_timing <= 1'h0;
        al(8'h90, 1'h1, 1'h0, 4'h0, 4'hf, 4'h3, 4'h0);
        al(8'h10, 1'h1, 1'h0, 4'h5, 4'h0, 4'h1, 4'h0);
        al(8'h02, 1'h0, 1'h1, 4'h0, 4'hf, 4'hf, 4'hf);
        al(8'h00, 1'h1, 1'h1, 4'hf, 4'h0, 4'h0, 4'h0);
        al(8'h00, 1'h0, 1'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        ind(1'h0);
        ind(1'h1);
        null_column_group <= 2'h1; null_pointer_group_b_enable <= 1'h1; null_column_slot <= 1'h1;
        apb(1'h1, 12'h04c, 32'h08);
        repeat (3) @(posedge clk);
        chk("fill_oe_n", bus_data_oe_n_ff, 1'h0);
        chk("fill_byte", bus_data_ff, 8'h00);
        null_column_group <= 2'h2;
        repeat (3) @(posedge clk);
        chk("other_group", bus_data_oe_n_ff, 1'h1);
        null_column_group <= 2'h1;
        apb(1'h1, 12'h04c, 32'h00);
        repeat (3) @(posedge clk);
        chk("hiz_oe_n", bus_data_oe_n_ff, 1'h1);
        obit_sw_values <= 16'h9c3a;
        repeat (3) @(posedge clk);
        chk("obit_pass", obit_tx_ff, 16'h9c3a);
        apb(1'h1, 12'h04c, 32'h01);
        repeat (3) @(posedge clk);
        chk("obit_zero", obit_tx_ff, 16'h0);
        apb(1'h1, 12'h04c, 32'h9f);
        apb(1'h1, 12'h054, 32'h80);
        repeat (6) @(posedge clk);
        apb(1'h0, 12'h04c, 32'h0);
        chk("master_reset", rd, 32'h0);
        results();
    end
endmodule // mcdac_common_ctrl_tb
